// ---- rtl/ppio_pkg.sv ----
// Package for the parallel port block: register map, reset values, types.
// Assumes a core side register port on the system clock.
package ppio_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_PORT2 = 8'hA0;
  localparam logic [7:0] ADDR_FLAGS = 8'hAD;
  localparam logic [7:0] ADDR_PORT3 = 8'hB0;

  // ****************************************
  // Reset values and fields
  // ****************************************
  localparam logic [7:0] LATCH_RESET = 8'hFF;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAGS_MASK = 8'hF0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int NUM_PORTS = 4;
  localparam int EDGE_PORT = 1;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic rmw;
    logic bit_op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } ppio_req_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pull;
  } ppio_pin_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_INIT
  } ppio_state_t;

endpackage

// ---- rtl/ppio_latch_mem.sv ----
// Four byte latch store with registered read data.
// Assumes one write port and one read port on the system clock.
`timescale 1ns/100ps
module ppio_latch_mem (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Write side
  input wire logic i_we,
  input wire logic [1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  // Read side
  input wire logic [1:0] i_raddr,
  output logic [7:0] o_rdata,
  // All latches
  output logic [31:0] o_all
);

  typedef struct packed {
    logic [3:0][7:0] mem;
    logic [7:0] rdata;
  } ppio_mem_st_t;

  ppio_mem_st_t st;
  ppio_mem_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.rdata = st.mem[i_raddr];
    if (i_we) begin
      next_st.mem[i_waddr] = i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st.mem <= {4{ppio_pkg::LATCH_RESET}};
      st.rdata <= ppio_pkg::LATCH_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_all = st.mem;

endmodule // ppio_latch_mem

// ---- rtl/ppio_top.sv ----
// Four general purpose ports with latches, pin readback and edge flags.
// Assumes the core gives byte or bit requests, flagging read-modify-write.
`timescale 1ns/100ps

module ppio_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Core request, rmw flag set by core decode of modify instructions
  input wire ppio_pkg::ppio_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Driver configuration
  input wire logic [31:0] i_driver_type_config,
  input wire logic i_pullup_disable,
  // Pins
  input wire logic [31:0] i_pin,
  output logic [31:0] o_pin,
  output logic [31:0] o_pin_oe,
  output logic [31:0] o_pin_pullup
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [3:0] prev;
    logic [7:0] edge_flag_register;
    logic pend;
    logic [1:0] pend_port;
    ppio_pkg::ppio_req_t pend_req;
    logic [7:0] rdata;
    logic rvalid;
    logic [31:0] pin_o;
    logic [31:0] pin_oe;
    logic [31:0] pin_pu;
  } ppio_st_t;

  ppio_st_t st;
  ppio_st_t next_st;

  logic mem_we;
  logic [1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [1:0] mem_raddr;
  logic [7:0] mem_rdata;
  logic [31:0] latches;

  function automatic logic is_port(input logic [7:0] a);
    return a == ppio_pkg::ADDR_PORT0 || a == ppio_pkg::ADDR_PORT1 ||
           a == ppio_pkg::ADDR_PORT2 || a == ppio_pkg::ADDR_PORT3;
  endfunction

  function automatic logic [1:0] port_idx(input logic [7:0] a);
    return a[5:4] - 2'h0;
  endfunction

  function automatic logic [7:0] merge_bit(input logic [7:0] base,
                                           input ppio_pkg::ppio_req_t r);
    logic [7:0] v;
    v = base;
    if (r.bit_op) begin
      v[r.bit_sel] = r.wdata[0];
    end else begin
      v = r.wdata;
    end
    return v;
  endfunction

  ppio_latch_mem u_mem (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata),
    .o_all(latches)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] pinbyte;
    logic [3:0] fall;
    logic [7:0] fl;
    pinbyte = 8'h00;
    fall = 4'h0;
    fl = 8'h00;
    next_st = st;
    mem_we = 1'b0;
    mem_waddr = port_idx(i_req.addr);
    mem_wdata = 8'h00;
    mem_raddr = port_idx(i_req.addr);
    next_st.rvalid = 1'b0;
    next_st.sync1 = i_pin;
    next_st.sync2 = st.sync1;
    // Edge detect on port 1 high nibble
    next_st.prev = st.sync2[ppio_pkg::EDGE_PORT*8+4 +: 4];
    fall = st.prev & ~st.sync2[ppio_pkg::EDGE_PORT*8+4 +: 4];
    fl = st.edge_flag_register;
    next_st.pend = 1'b0;
    if (st.pend) begin
      // Latch value is back: modify and write it
      mem_we = 1'b1;
      mem_waddr = st.pend_port;
      mem_wdata = merge_bit(mem_rdata, st.pend_req);
      next_st.rdata = mem_rdata;
      next_st.rvalid = 1'b1;
    end else if (is_port(i_req.addr) && i_req.rmw) begin
      next_st.pend = 1'b1;
      next_st.pend_port = port_idx(i_req.addr);
      next_st.pend_req = i_req;
    end else if (is_port(i_req.addr) && i_req.wr) begin
      mem_we = 1'b1;
      mem_wdata = merge_bit(latches[port_idx(i_req.addr)*8 +: 8], i_req);
    end else if (is_port(i_req.addr) && i_req.rd) begin
      pinbyte = st.sync2[port_idx(i_req.addr)*8 +: 8];
      next_st.rdata = i_req.bit_op ?
        {7'h00, pinbyte[i_req.bit_sel]} : pinbyte;
      next_st.rvalid = 1'b1;
    end else if (i_req.addr == ppio_pkg::ADDR_FLAGS && i_req.wr) begin
      fl = merge_bit(st.edge_flag_register, i_req) & ppio_pkg::FLAGS_MASK;
    end else if (i_req.addr == ppio_pkg::ADDR_FLAGS && i_req.rd) begin
      next_st.rdata = i_req.bit_op ?
        {7'h00, st.edge_flag_register[i_req.bit_sel]} :
        st.edge_flag_register;
      next_st.rvalid = 1'b1;
    end
    // Set wins over clear
    next_st.edge_flag_register = fl | {fall, 4'h0};
    // Drivers for all ports, bonded or not
    for (int i = 0; i < 32; i++) begin
      next_st.pin_o[i] = latches[i];
      next_st.pin_oe[i] = i_driver_type_config[i] | ~latches[i];
      next_st.pin_pu[i] = ~i_driver_type_config[i] & ~i_pullup_disable &
                          latches[i];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st.sync1 <= '1;
      st.sync2 <= '1;
      st.prev <= 4'hF;
      st.edge_flag_register <= ppio_pkg::FLAGS_RESET;
      st.pend <= 1'b0;
      st.pend_port <= 2'h0;
      st.pend_req <= '0;
      st.rdata <= 8'h00;
      st.rvalid <= 1'b0;
      st.pin_o <= {4{ppio_pkg::LATCH_RESET}};
      st.pin_oe <= {4{ppio_pkg::CFG_RESET}};
      st.pin_pu <= '1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_rdata = st.rdata;
  assign o_rvalid = st.rvalid;
  assign o_pin = st.pin_o;
  assign o_pin_oe = st.pin_oe;
  assign o_pin_pullup = st.pin_pu;

endmodule // ppio_top

// ---- sim/ppio_checker.sv ----
// Checker for the port block, watching only the top ports.
// Assumes it is bound onto ppio_top.
`timescale 1ns/100ps
module ppio_checker (
  // Clock, reset and core side
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire ppio_pkg::ppio_req_t i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  // Config and pins
  input wire logic [31:0] i_driver_type_config,
  input wire logic i_pullup_disable,
  input wire logic [31:0] i_pin,
  input wire logic [31:0] o_pin,
  input wire logic [31:0] o_pin_oe,
  input wire logic [31:0] o_pin_pullup
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic p_map;
  assign p_map = i_req.addr[3:0] == 4'h0 && i_req.addr[7:6] == 2'h2;
  // ****************************************
  // Request shapes
  // ****************************************
  sequence s_rmw;
    i_req.rmw && p_map && !$past(i_req.rmw);
  endsequence
  sequence s_rd;
    i_req.rd && !i_req.wr && !i_req.rmw && p_map && !$past(i_req.rmw);
  endsequence
  sequence s_wr;
    i_req.wr && !i_req.rmw && !i_req.bit_op && !$past(i_req.rmw) &&
      i_req.addr == ppio_pkg::ADDR_PORT0;
  endsequence
  a_read_answer: assert property (s_rd |=> o_rvalid)
    else $error("read without answer");
  a_rmw_answer: assert property (s_rmw |=> !o_rvalid ##1 o_rvalid)
    else $error("modify answer late");
  a_write_pins: assert property (
    s_wr |=> ##1 o_pin[7:0] == $past(i_req.wdata, 2))
    else $error("write not on pins");
  a_rvalid_cause: assert property (
    o_rvalid |-> $past(i_req.rd) || $past(i_req.rmw, 2))
    else $error("answer without request");
  a_unmapped_quiet: assert property (
    i_req.rd && !i_req.rmw && !p_map && i_req.addr != ppio_pkg::ADDR_FLAGS
    && !$past(i_req.rmw) |=> !o_rvalid) else $error("unmapped answered");
  a_oe_type: assert property (!$past(i_rst) |->
    o_pin_oe == ($past(i_driver_type_config) | ~o_pin))
    else $error("driver enable wrong");
  a_pullup_rule: assert property (!$past(i_rst) |->
    o_pin_pullup == (~$past(i_driver_type_config) & o_pin &
    {32{!$past(i_pullup_disable)}})) else $error("pull-up wrong");
  a_latch_hold: assert property (
    !(i_req.wr || i_req.rmw) [*4] |=> $stable(o_pin))
    else $error("latch moved");
endmodule // ppio_checker

bind ppio_top ppio_checker u_chk (.*);

// ---- sim/ppio_board.sv ----
// Board model: pin wiring with pull-ups and outside drivers.
// Assumes per pin enables from the port block and the bench.
`timescale 1ns/100ps
module ppio_board (
  // From the port block
  input wire logic [31:0] i_o,
  input wire logic [31:0] i_oe,
  input wire logic [31:0] i_pu,
  // Outside drivers
  input wire logic [31:0] i_ext,
  input wire logic [31:0] i_ext_en,
  // Resolved level
  output logic [31:0] o_lvl
);
  // Floating pins read high with the pull-up on, else show the inverse of the latch
  assign o_lvl = (i_oe & i_o) | (~i_oe & i_ext_en & i_ext) |
    (~i_oe & ~i_ext_en & (i_pu | ~i_o));
endmodule // ppio_board

// ---- sim/test_ppio_top.sv ----
// Testbench for the port block: core requests, pins, config.
// Assumes ppio_top, its checker bind and the board model.
`timescale 1ns/100ps
module test_ppio_top;
  logic i_sys_clk = 0, i_rst = 1, pud = 0, rv;
  ppio_pkg::ppio_req_t rq = '0;
  logic [31:0] cfg = 32'hFF00_0000;
  logic [31:0] ext = 32'h0000_003C, en = '0, lvl, pin, oe, pu;
  logic [7:0] rd;
  int n_fail = 0, num_checks = 0;
  ppio_top u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(rq),
    .o_rdata(rd), .o_rvalid(rv), .i_driver_type_config(cfg),
    .i_pullup_disable(pud), .i_pin(lvl), .o_pin(pin), .o_pin_oe(oe),
    .o_pin_pullup(pu));
  ppio_board u_board (.i_o(pin), .i_oe(oe), .i_pu(pu), .i_ext(ext),
    .i_ext_en(en), .o_lvl(lvl));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task automatic idle(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Request kinds: write, read, modify, bit
  task automatic go(input logic [3:0] k, input logic [7:0] a,
      input logic [2:0] s, input logic [7:0] d);
    @(negedge i_sys_clk);
    rq = {k, a, s, d};
    @(negedge i_sys_clk);
    rq = '0;
  endtask
  task automatic get(input logic [3:0] k, input logic [7:0] a, d, e);
    go(k, a, 3'h0, d);
    for (int i = 0; i < 3 && !rv; i++) @(negedge i_sys_clk);
    chk({31'h0, rv}, 32'h1);
    chk({24'h0, rd}, {24'h0, e});
  endtask
  task automatic conclude();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    idle(10);
    i_rst = 0;
    idle(3);
    chk(pin, 32'hFFFF_FFFF);
    chk(pu, 32'h00FF_FFFF);
    for (int p = 0; p < 4; p++) begin
      go(4'h8, 8'h80 + 8'(p * 16), 3'h0, 8'hA5 ^ 8'(p));
    end
    idle(3);
    chk(pin, 32'hA6A7_A4A5);
    chk(oe, 32'hFF58_5B5A);
    chk(pu, 32'h00A7_A4A5);
    pud = 1;
    idle(3);
    chk(pu, 32'h0);
    pud = 0;
    en = 32'h0000_00FF;
    idle(4);
    get(4'h4, 8'h80, 8'h00, 8'h24);
    get(4'h4, 8'hB0, 8'h00, 8'hA6);
    go(4'h4, 8'h81, 3'h0, 8'h00);
    get(4'h2, 8'h80, 8'hA7, 8'hA5);
    go(4'h3, 8'h90, 3'h7, 8'h00);
    go(4'h9, 8'hA0, 3'h0, 8'h00);
    idle(3);
    chk(pin, 32'hA6A6_24A7);
    go(4'h8, 8'h90, 3'h0, 8'hFF);
    idle(8);
    go(4'h8, 8'hAD, 3'h0, 8'h00);
    get(4'h4, 8'hAD, 8'h00, 8'h00);
    go(4'h8, 8'h90, 3'h0, 8'h0F);
    idle(8);
    get(4'h4, 8'hAD, 8'h00, 8'hF0);
    go(4'h8, 8'hAD, 3'h0, 8'h50);
    get(4'h4, 8'hAD, 8'h00, 8'h50);
    conclude();
  end
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
endmodule // test_ppio_top
